// ===== src/bhm_cfg.svh
// constants for the byte hardware multiplier
// assumes inclusion by bare name from package and modules
`ifndef BHM_CFG_SVH
`define BHM_CFG_SVH
`define BHM_OPND_W      8
`define BHM_PROD_W      16
`define BHM_PROD_HI_MSB 15
`define BHM_PROD_HI_LSB 8
`define BHM_PROD_LO_MSB 7
`define BHM_PROD_LO_LSB 0
`define BHM_PROD_RST    8'h00
`define BHM_FLAGS_RST   8'h00
`define BHM_FLAGS_W     8
`endif

// ===== src/bhm_pkg.sv
// types for the byte hardware multiplier
// assumes bhm_cfg.svh is on the include path
`include "bhm_cfg.svh"
package bhm_pkg;
  typedef logic [`BHM_OPND_W-1:0] bhm_byte_t;
  typedef logic [`BHM_PROD_W-1:0] bhm_prod_t;
  typedef logic [`BHM_FLAGS_W-1:0] bhm_flags_t;
endpackage

// ===== src/bhm_mul_core.sv
// combinational unsigned 8 x 8 array multiplier
// assumes operands are stable within the instruction cycle
`timescale 1ns/1ps
`include "bhm_cfg.svh"
module bhm_mul_core
  import bhm_pkg::*;
(
  input  wire bhm_pkg::bhm_byte_t mcand_in,
  input  wire bhm_pkg::bhm_byte_t mplier_in,
  output wire bhm_pkg::bhm_prod_t prod_out
);
  // ****************************************
  // partial products
  // ****************************************
  bhm_prod_t pp [`BHM_OPND_W];
  bhm_prod_t acc [`BHM_OPND_W+1];
  assign acc[0] = '0;
  genvar i;
  generate
    for (i = 0; i < `BHM_OPND_W; i = i + 1)
    begin : g_row
      assign pp[i]    = bhm_prod_t'({8'h00, mcand_in & {`BHM_OPND_W{mplier_in[i]}}} << i);
      assign acc[i+1] = acc[i] + pp[i];
    end
  endgenerate
  assign prod_out = acc[`BHM_OPND_W];
endmodule // bhm_mul_core

// ===== src/bhm_multiplier.sv
// byte hardware multiplier inside the alu: product register pair
// assumes core execute logic drives strobes in the instruction cycle
// assumes operands and strobes come from logic on ref_clk_in
// assumes software writes and multiplies share one write-back slot
// assumes the alu owns the flags and only passes them through here
`timescale 1ns/1ps
`include "bhm_cfg.svh"
module bhm_multiplier
  import bhm_pkg::*;
(
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire bhm_pkg::bhm_byte_t working_register_in,
  input  wire bhm_pkg::bhm_byte_t mem_operand_in,
  input  wire logic              multiply_by_working_instr_in,
  input  wire logic              wr_prod_high_in,
  input  wire logic              wr_prod_low_in,
  input  wire bhm_pkg::bhm_byte_t wr_data_in,
  input  wire bhm_pkg::bhm_flags_t alu_status_in,
  output logic                   mul_busy_out,
  output bhm_pkg::bhm_byte_t     product_high_reg_out,
  output bhm_pkg::bhm_byte_t     product_low_reg_out,
  output bhm_pkg::bhm_flags_t    alu_status_reg_out
);
  import bhm_pkg::*;

  // ****************************************
  // operand view
  // ****************************************
  // same-clock core logic, so no synchroniser
  // no operand registers: trades timing slack for zero latency
  bhm_byte_t mcand;
  bhm_byte_t mplier;

  always_comb
  begin
    mcand  = working_register_in;
    mplier = mem_operand_in;
  end

  // ****************************************
  // multiplier array
  // ****************************************
  // purely combinational, must settle in one cycle
  bhm_prod_t product;
  bhm_byte_t mul_high;
  bhm_byte_t mul_low;

  bhm_mul_core u_core
  (
    .mcand_in  (mcand),
    .mplier_in (mplier),
    .prod_out  (product)
  );

  assign mul_high = product[`BHM_PROD_HI_MSB:`BHM_PROD_HI_LSB];
  assign mul_low  = product[`BHM_PROD_LO_MSB:`BHM_PROD_LO_LSB];

  // ****************************************
  // software write port
  // ****************************************
  bhm_byte_t wr_byte;
  logic      wr_any;

  always_comb
  begin
    wr_byte = wr_data_in;
    wr_any  = wr_prod_high_in | wr_prod_low_in;
  end

  // ****************************************
  // update select
  // ****************************************
  logic load_mul;
  logic load_high;
  logic load_low;

  // multiply wins: a same-cycle write would tear the pair
  always_comb
  begin
    load_mul  = multiply_by_working_instr_in;
    load_high = 1'b0;
    load_low  = 1'b0;
    if (multiply_by_working_instr_in)
    begin
      load_high = 1'b0;
      load_low  = 1'b0;
    end
    else if (wr_any)
    begin
      // one or both bytes by software
      load_high = wr_prod_high_in;
      load_low  = wr_prod_low_in;
    end
  end

  // ****************************************
  // next product values
  // ****************************************
  bhm_byte_t next_product_high;
  bhm_byte_t next_product_low;

  always_comb
  begin
    next_product_high = product_high_reg_out;
    if (load_mul)
    begin
      next_product_high = mul_high;
    end
    else if (load_high)
    begin
      next_product_high = wr_byte;
    end
  end

  always_comb
  begin
    next_product_low = product_low_reg_out;
    if (load_mul)
    begin
      next_product_low = mul_low;
    end
    else if (load_low)
    begin
      next_product_low = wr_byte;
    end
  end

  // ****************************************
  // product register pair
  // ****************************************
  // zero after reset, software must not rely on it
  // high byte, same edge as the low byte
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      product_high_reg_out <= `BHM_PROD_RST;
    end
    else
    begin
      product_high_reg_out <= next_product_high;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      product_low_reg_out <= `BHM_PROD_RST;
    end
    else
    begin
      product_low_reg_out <= next_product_low;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  bhm_flags_t next_status;

  // multiply never touches the flags
  // no flag logic here; the alu owns them
  always_comb
  begin
    next_status = alu_status_in;
  end

  // one cycle of latency, like the product pair
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      alu_status_reg_out <= `BHM_FLAGS_RST;
    end
    else
    begin
      alu_status_reg_out <= next_status;
    end
  end

  // ****************************************
  // stall
  // ****************************************
  logic next_busy;

  // single cycle, so the core never waits
  always_comb
  begin
    next_busy = 1'b0;
  end

  // kept as a port so the core interface stays fixed
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mul_busy_out <= 1'b0;
    end
    else
    begin
      mul_busy_out <= next_busy;
    end
  end
endmodule // bhm_multiplier

// ===== test/bhm_monitor.sv
// port checker for bhm_multiplier
// bound from tb_top
`timescale 1ns/1ps
module bhm_monitor
  import bhm_pkg::*;
(
  input wire logic ref_clk_in, rst_n_in, multiply_by_working_instr_in, wr_prod_high_in, wr_prod_low_in, mul_busy_out,
  input wire bhm_byte_t working_register_in, mem_operand_in, wr_data_in, product_high_reg_out, product_low_reg_out,
  input wire bhm_flags_t alu_status_in, alu_status_reg_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_mul;
    multiply_by_working_instr_in;
  endsequence
  sequence s_wr_high;
    !multiply_by_working_instr_in && wr_prod_high_in;
  endsequence
  a_no_stall: assert property (!mul_busy_out) else $error("busy seen");
  a_low_byte: assert property (s_mul |=> product_low_reg_out ==
    8'($past(working_register_in) * $past(mem_operand_in))) else $error("low byte wrong");
  a_sw_high: assert property (s_wr_high |=> product_high_reg_out == $past(wr_data_in))
    else $error("high write lost");
  a_full_prod: assert property (s_mul |=> {product_high_reg_out, product_low_reg_out} ==
    $past(working_register_in) * $past(mem_operand_in)) else $error("product wrong");
  a_high_byte: assert property (s_mul |=> product_high_reg_out ==
    8'(({8'h00, $past(working_register_in)} * $past(mem_operand_in)) >> 8)) else $error("high byte wrong");
  a_flags_kept: assert property (s_mul |=> alu_status_reg_out == $past(alu_status_in)) else $error("flags moved");
  a_prod_hold: assert property (!multiply_by_working_instr_in && !wr_prod_high_in && !wr_prod_low_in
    |=> $stable({product_high_reg_out, product_low_reg_out})) else $error("product drifted");
endmodule // bhm_monitor

// ===== test/bhm_core_model.sv
// execute-stage model issuing multiplies
// operands released show their inverse
`timescale 1ns/1ps
module bhm_core_model
  import bhm_pkg::*;
(
  input  wire logic ref_clk_in,
  output bhm_byte_t w_out,
  output bhm_byte_t m_out,
  output logic      mul_out
);
  initial {w_out, m_out, mul_out} = '0;
  task automatic issue(input bhm_byte_t a, input bhm_byte_t b, input logic hold);
    @(negedge ref_clk_in);
    {w_out, m_out, mul_out} = {a, b, 1'b1};
    if (!hold)
    begin
      @(negedge ref_clk_in);
      {w_out, m_out, mul_out} = {~a, ~b, 1'b0};
    end
  endtask
endmodule // bhm_core_model

// ===== test/tb_top.sv
// bench for bhm_multiplier
// core model drives the execute side
`timescale 1ns/1ps
module tb_top;
  import bhm_pkg::*;
  logic clk = 0, rst_n = 0, wh = 0, wl = 0, mul, busy;
  bhm_byte_t w, m, d = '0, hi, lo;
  bhm_flags_t st = 8'h5a, so;
  int n_mismatch = 0, checks_done = 0;
  logic [31:0] res;
  bhm_prod_t rows [4][3] = '{'{16'h00ff, 16'h00ff, 16'hfe01}, '{16'h0000, 16'h007b, 16'h0000},
    '{16'h0080, 16'h0002, 16'h0100}, '{16'h000f, 16'h0011, 16'h00ff}};
  always #10 clk = ~clk;
  bhm_core_model core (.ref_clk_in(clk), .w_out(w), .m_out(m), .mul_out(mul));
  bhm_multiplier dut (.ref_clk_in(clk), .rst_n_in(rst_n), .working_register_in(w), .mem_operand_in(m),
    .multiply_by_working_instr_in(mul), .wr_prod_high_in(wh), .wr_prod_low_in(wl), .wr_data_in(d),
    .alu_status_in(st), .mul_busy_out(busy), .product_high_reg_out(hi), .product_low_reg_out(lo),
    .alu_status_reg_out(so));
  task automatic chk(input bhm_prod_t e);
    checks_done++;
    if ({hi, lo} !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED product exp %h got %h", e, {hi, lo});
    end
    if (so !== st || busy !== 1'b0)
    begin
      n_mismatch++;
      $display("CHECK FAILED status exp %h busy 0 got %h busy %b", st, so, busy);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    foreach (rows[i])
    begin
      st = ~rows[i][0][7:0];
      core.issue(rows[i][0][7:0], rows[i][1][7:0], 1'b0);
      chk(rows[i][2]);
    end
    core.issue(8'h12, 8'h34, 1'b1);
    @(posedge clk);
    #1 chk(16'h03a8);
    core.issue(8'hc3, 8'h3c, 1'b0);
    repeat (3) @(negedge clk);
    chk(16'h2db4);
    {wh, wl, d} = {2'b11, 8'h77};
    @(negedge clk);
    {wh, wl} = 2'b00;
    chk(16'h7777);
    core.issue(8'h05, 8'h07, 1'b1);
    {wh, wl, d} = {2'b11, 8'h99};
    @(negedge clk);
    {wh, wl} = 2'b00;
    core.issue(8'h05, 8'h07, 1'b0);
    chk(16'h0023);
    core.issue(8'hfe, 8'h03, 1'b0);
    {wh, d} = {1'b1, hi - 8'h03};
    @(negedge clk);
    wh = 1'b0;
    chk(16'hfffa);
    res = '0;
    for (int k = 0; k < 4; k++)
    begin
      core.issue(k[0] ? 8'h12 : 8'h34, k[1] ? 8'h56 : 8'h78, 1'b0);
      res = res + ({16'h0000, hi, lo} << (8 * (k[0] + k[1])));
    end
    checks_done++;
    if (res !== 32'h06260060)
    begin
      n_mismatch++;
      $display("CHECK FAILED wide product exp 06260060 got %h", res);
    end
    rst_n = 0;
    #1;
    checks_done++;
    if ({hi, lo, so, busy} !== 25'h0000000)
    begin
      n_mismatch++;
      $display("CHECK FAILED reset outputs exp 0000000 got %h", {hi, lo, so, busy});
    end
    @(negedge clk);
    rst_n = 1;
    core.issue(8'h02, 8'h03, 1'b0);
    chk(16'h0006);
    stop_test();
  end
endmodule // tb_top
bind bhm_multiplier bhm_monitor mon (.*);
